// ---- logic/clkgen_pkg.sv ----
// shared types and constants for the clock divider with ready and reset sync
package clkgen_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40; // sampling clock period

  // ----------------------------------------------------------------
  // pin group carried through the input synchroniser
  // ----------------------------------------------------------------
  typedef struct packed {
    logic osc;     // crystal oscillator, digital form
    logic external_freq_in;     // external frequency input
    logic sel;     // source-select strap
    logic clear;   // phase-align clear
    logic req;     // reset request, active low
    logic done1;   // bus done one
    logic done2;   // bus done two
    logic q1_n;    // qualifier one, active low
    logic q2_n;    // qualifier two, active low
    logic depth;   // sync depth select
  } pins_t;

  localparam pins_t PINS_RESET = '0;

  // ----------------------------------------------------------------
  // divide-by-three phase
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_HIGH = 2'h0, // processor clock high
    PH_FALL = 2'h1, // first low third
    PH_LOW  = 2'h3  // second low third
  } phase_t;

  localparam phase_t PHASE_RESET = PH_LOW;

  // ----------------------------------------------------------------
  // main state
  // ----------------------------------------------------------------
  typedef struct packed {
    phase_t ph;
    logic src_prev;
    logic proc_clk;
    logic periph_clk;
    logic osc_tap;
    logic proc_reset;
    logic rdy_one;
    logic rdy_two;
  } state_t;

  localparam logic PROC_RESET_INIT = 1'h1;
  localparam logic CLOCK_INIT = 1'h0;
  localparam logic READY_INIT = 1'h0;

endpackage : clkgen_pkg

// ---- logic/pin_sync.sv ----
// two flip-flop synchroniser for the pin group
`timescale 1ns/10ps

module pin_sync
(
  input wire logic clk,
  input wire logic rst_n,
  input wire clkgen_pkg::pins_t d,
  output clkgen_pkg::pins_t q
);

  typedef struct packed {
    clkgen_pkg::pins_t meta;
    clkgen_pkg::pins_t stable;
  } sync_t;

  sync_t s_q;
  sync_t s_d;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // meta only feeds stable
  always_comb
  begin
    s_d = s_q;
    s_d.meta = d;
    s_d.stable = s_q.meta;
  end

  // synchronous reset register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_q.meta <= clkgen_pkg::PINS_RESET;
      s_q.stable <= clkgen_pkg::PINS_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign q = s_q.stable;

endmodule : pin_sync

// ---- logic/clock_divider_ready_reset_sync.sv ----
// clock divider, reset synchroniser and ready synchroniser
`timescale 1ns/10ps

// How it works
// - processor reset output is active high and follows the reset request
// - clear input high holds divider phase; low lets it count again
// - divide selected source by three giving one-third high processor clock
// - static strap picks crystal oscillator or external frequency input
// - strap low uses oscillator, strap high uses external input
// - oscillator copy always appears on the tap output
// - peripheral clock is half processor clock at fifty percent duty
// - reset request is registered on processor clock falling edge
// - each bus done counts only while its low qualifier is asserted
// - two-stage mode: rise via first flop then second flop
// - two-stage mode: falling request clears second flop directly
// - select high bypasses first flop, second flop samples on fall
// - depth select may change every bus cycle and applies at once
// - ready clears only on a falling edge, after processor hold
module clock_divider_ready_reset_sync
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic OSC_SOURCE,
  input wire logic EXTERNAL_FREQ_IN,
  input wire logic SOURCE_SELECT,
  input wire logic PHASE_ALIGN_CLEAR,
  input wire logic RESET_REQUEST_IN,
  input wire logic BUS_DONE_ONE,
  input wire logic BUS_DONE_TWO,
  input wire logic QUALIFIER_ONE_N,
  input wire logic QUALIFIER_TWO_N,
  input wire logic SYNC_DEPTH_SELECT,
  output logic PROC_CLK,
  output logic PERIPH_CLK,
  output logic OSC_TAP,
  output logic PROC_RESET,
  output logic READY
);

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  clkgen_pkg::pins_t pins_raw;
  clkgen_pkg::pins_t p;

  // gather pins into the carrier
  always_comb
  begin
    pins_raw.osc = OSC_SOURCE;
    pins_raw.external_freq_in = EXTERNAL_FREQ_IN;
    pins_raw.sel = SOURCE_SELECT;
    pins_raw.clear = PHASE_ALIGN_CLEAR;
    pins_raw.req = RESET_REQUEST_IN;
    pins_raw.done1 = BUS_DONE_ONE;
    pins_raw.done2 = BUS_DONE_TWO;
    pins_raw.q1_n = QUALIFIER_ONE_N;
    pins_raw.q2_n = QUALIFIER_TWO_N;
    pins_raw.depth = SYNC_DEPTH_SELECT;
  end

  pin_sync u_sync
  (
    .clk(CLK),
    .rst_n(RST_N),
    .d(pins_raw),
    .q(p)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // qualified ready request
  function automatic logic ready_request(input clkgen_pkg::pins_t v);
    ready_request = (v.done1 & ~v.q1_n) | (v.done2 & ~v.q2_n);
  endfunction : ready_request

  // selected divider source
  function automatic logic source_of(input clkgen_pkg::pins_t v);
    source_of = v.sel ? v.external_freq_in : v.osc;
  endfunction : source_of

  clkgen_pkg::state_t s_q;
  clkgen_pkg::state_t s_d;
  logic src_now;
  logic src_rise;
  logic proc_rise;
  logic proc_fall;
  logic rdy_req;

  // source edge and divider events
  always_comb
  begin
    src_now = source_of(p);
    src_rise = src_now & ~s_q.src_prev;
    proc_rise = src_rise & ~p.clear & (s_q.ph == clkgen_pkg::PH_LOW);
    proc_fall = src_rise & ~p.clear & (s_q.ph == clkgen_pkg::PH_HIGH);
    rdy_req = ready_request(p);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.src_prev = src_now;
    s_d.osc_tap = p.osc;
    if (p.clear)
    begin
      s_d.ph = clkgen_pkg::PH_LOW;
    end
    else if (src_rise)
    begin
      case (s_q.ph)
        clkgen_pkg::PH_HIGH: s_d.ph = clkgen_pkg::PH_FALL;
        clkgen_pkg::PH_FALL: s_d.ph = clkgen_pkg::PH_LOW;
        clkgen_pkg::PH_LOW: s_d.ph = clkgen_pkg::PH_HIGH;
        default: s_d.ph = clkgen_pkg::PHASE_RESET;
      endcase
    end
    s_d.proc_clk = (s_d.ph == clkgen_pkg::PH_HIGH);
    if (proc_fall)
    begin
      s_d.periph_clk = ~s_q.periph_clk;
    end
    if (proc_fall)
    begin
      s_d.proc_reset = ~p.req;
    end
    if (proc_rise)
    begin
      s_d.rdy_one = rdy_req;
    end
    if (proc_fall)
    begin
      if (p.depth)
      begin
        s_d.rdy_two = rdy_req;
      end
      else
      begin
        s_d.rdy_two = s_q.rdy_one & rdy_req;
      end
    end
  end

  // state register, synchronous reset
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      s_q.ph <= clkgen_pkg::PHASE_RESET;
      s_q.src_prev <= clkgen_pkg::CLOCK_INIT;
      s_q.proc_clk <= clkgen_pkg::CLOCK_INIT;
      s_q.periph_clk <= clkgen_pkg::CLOCK_INIT;
      s_q.osc_tap <= clkgen_pkg::CLOCK_INIT;
      s_q.proc_reset <= clkgen_pkg::PROC_RESET_INIT;
      s_q.rdy_one <= clkgen_pkg::READY_INIT;
      s_q.rdy_two <= clkgen_pkg::READY_INIT;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign PROC_CLK = s_q.proc_clk;
  assign PERIPH_CLK = s_q.periph_clk;
  assign OSC_TAP = s_q.osc_tap;
  assign PROC_RESET = s_q.proc_reset;
  assign READY = s_q.rdy_two;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  property p_clk_rise;
    proc_rise |=> PROC_CLK;
  endproperty
  a_clk_rise: assert property (p_clk_rise) else $error("clock not high after rise");

  property p_clk_fall;
    proc_fall |=> !PROC_CLK ##1 !PROC_CLK;
  endproperty
  a_clk_fall: assert property (p_clk_fall) else $error("clock not low after fall");

  property p_clear_hold;
    p.clear |=> (s_q.ph == clkgen_pkg::PH_LOW) && !PROC_CLK;
  endproperty
  a_clear_hold: assert property (p_clear_hold) else $error("clear did not hold divider");

  property p_source;
    src_rise |-> (p.sel ? $rose(p.external_freq_in) : $rose(p.osc));
  endproperty
  a_source: assert property (p_source) else $error("wrong divider source");

  property p_tap;
    ##1 OSC_TAP == $past(p.osc);
  endproperty
  a_tap: assert property (p_tap) else $error("oscillator tap mismatch");

  property p_periph;
    proc_fall |=> PERIPH_CLK != $past(PERIPH_CLK);
  endproperty
  a_periph: assert property (p_periph) else $error("peripheral clock did not toggle");

  property p_periph_hold;
    !proc_fall |=> $stable(PERIPH_CLK);
  endproperty
  a_periph_hold: assert property (p_periph_hold) else $error("peripheral clock moved");

  property p_reset_edge;
    $changed(PROC_RESET) |-> $past(proc_fall);
  endproperty
  a_reset_edge: assert property (p_reset_edge) else $error("reset moved off falling edge");

  property p_reset_value;
    proc_fall |=> PROC_RESET == !$past(p.req);
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("reset level wrong");

  property p_unqualified;
    proc_fall && !ready_request(p) |=> !READY;
  endproperty
  a_unqualified: assert property (p_unqualified) else $error("ready without request");

  property p_two_stage;
    proc_fall && !p.depth && !s_q.rdy_one |=> !READY;
  endproperty
  a_two_stage: assert property (p_two_stage) else $error("first stage skipped");

  property p_one_stage;
    proc_fall && p.depth && rdy_req |=> READY;
  endproperty
  a_one_stage: assert property (p_one_stage) else $error("bypass mode did not ready");

  property p_ready_clear;
    $fell(READY) |-> $past(proc_fall);
  endproperty
  a_ready_clear: assert property (p_ready_clear) else $error("ready cleared off edge");

  c_ready_two: cover property (proc_fall && !p.depth ##[1:40] $rose(READY));
  c_ready_one: cover property (proc_fall && p.depth ##1 $rose(READY));
  c_reset_rel: cover property ($fell(PROC_RESET));
  c_clear: cover property ($fell(p.clear) ##[1:40] proc_rise);

endmodule : clock_divider_ready_reset_sync

// ---- tb/src_model.sv ----
// far-side model giving the source clocks and a clear aligned to the external input
`timescale 1ns/10ps

module src_model
(
  input wire logic clk,
  input wire logic clear_req,
  output logic osc,
  output logic external_freq_in,
  output logic clear
);
  int n = 0;
  logic stage_q = 1'b0;

  // ----------------------------------------
  // source clocks
  // ----------------------------------------
  // values at time zero
  initial
  begin
    osc = 1'b0;
    external_freq_in = 1'b0;
    clear = 1'b0;
  end

  // crystal period eight cycles, external period ten, so they differ
  always @(negedge clk)
  begin
    n <= n + 1;
    osc <= (n % 8) < 4;
    external_freq_in <= (n % 10) < 5;
  end

  // ----------------------------------------
  // phase-align clear
  // ----------------------------------------
  // clear synchronised externally
  always @(posedge external_freq_in)
  begin
    stage_q <= clear_req;
    clear <= stage_q;
  end
endmodule : src_model

// ---- tb/clock_divider_ready_reset_sync_test.sv ----
// self-checking bench of the clock divider with ready and reset sync
`timescale 1ns/10ps
`define CHECK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end

module clock_divider_ready_reset_sync_test;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic sel = 1'b0, rq = 1'b1, d1 = 1'b0, d2 = 1'b0, q1 = 1'b0, q2 = 1'b0, dep = 1'b0;
  logic clr_req = 1'b0;
  logic osc, external_freq_in, clr, prv, e_pc, e_pp, e_ot, e_pr, e_ff, e_rd;
  logic PROC_CLK, PERIPH_CLK, OSC_TAP, PROC_RESET, READY;
  logic [7:0] lf = 8'h5d; // seed 93
  logic [1:0] ph;
  logic [3:0] o_out;
  int err_count = 0;
  int checks_done = 0;
  clkgen_pkg::pins_t s1, s2;
  wire logic src_s = s2.sel ? s2.external_freq_in : s2.osc;
  wire logic rise = src_s & ~prv & ~s2.clear;

  // ----------------------------------------
  // clock, design and far side
  // ----------------------------------------
  initial
  begin
    forever #20 CLK = ~CLK;
  end

  clock_divider_ready_reset_sync DUT (.CLK(CLK), .RST_N(RST_N), .OSC_SOURCE(osc),
    .EXTERNAL_FREQ_IN(external_freq_in), .SOURCE_SELECT(sel), .PHASE_ALIGN_CLEAR(clr),
    .RESET_REQUEST_IN(rq), .BUS_DONE_ONE(d1), .BUS_DONE_TWO(d2), .QUALIFIER_ONE_N(q1),
    .QUALIFIER_TWO_N(q2), .SYNC_DEPTH_SELECT(dep), .PROC_CLK(PROC_CLK),
    .PERIPH_CLK(PERIPH_CLK), .OSC_TAP(OSC_TAP), .PROC_RESET(PROC_RESET), .READY(READY));

  src_model partner (.clk(CLK), .clear_req(clr_req), .osc(osc), .external_freq_in(external_freq_in), .clear(clr));

  // ----------------------------------------
  // expectation
  // ----------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr

  // qualified ready request
  function automatic logic req_of(input clkgen_pkg::pins_t p);
    return (p.done1 & ~p.q1_n) | (p.done2 & ~p.q2_n);
  endfunction : req_of

  // reference divider, reset and ready path
  always @(posedge CLK)
  begin
    s1 <= RST_N ? {osc, external_freq_in, sel, clr, rq, d1, d2, q1, q2, dep} : '0;
    s2 <= RST_N ? s1 : '0;
    prv <= RST_N & src_s;
    e_ot <= RST_N & s2.osc;
    if (!RST_N)
    begin
      e_pp <= 1'b0;
      e_pr <= 1'b1;
      e_ff <= 1'b0;
      e_rd <= 1'b0;
    end
    if (!RST_N || s2.clear)
    begin
      ph <= 2'h2;
      e_pc <= 1'b0;
    end
    else if (rise && ph == 2'h2)
    begin
      ph <= 2'h0;
      e_pc <= 1'b1;
      e_ff <= req_of(s2);
    end
    else if (rise && ph == 2'h0)
    begin
      ph <= 2'h1;
      e_pc <= 1'b0;
      e_pp <= ~e_pp;
      e_pr <= ~s2.req;
      e_rd <= req_of(s2) & (s2.depth | e_ff);
    end
    else if (rise)
      ph <= 2'h2;
  end

  // compare outputs where settled, then note them
  always @(negedge CLK)
  begin
    if (RST_N)
    begin
      `CHECK(PROC_CLK, e_pc)
      `CHECK(PERIPH_CLK, e_pp)
      `CHECK(OSC_TAP, e_ot)
      `CHECK(PROC_RESET, e_pr)
      `CHECK(READY, e_rd)
      if (PERIPH_CLK !== o_out[2]) `CHECK({o_out[3], PROC_CLK}, 2'h2)
      if (PROC_RESET !== o_out[1]) `CHECK({o_out[3], PROC_CLK}, 2'h2)
      if (READY !== o_out[0]) `CHECK({o_out[3], PROC_CLK}, 2'h2)
    end
    o_out <= {PROC_CLK, PERIPH_CLK, PROC_RESET, READY};
  end

  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  task automatic run(input string name, input logic s, input int qm, input int clr_at);
    for (int i = 0; i < 600; i++)
    begin
      @(negedge CLK);
      lf = lfsr(lf);
      sel <= s;
      // done inputs move only on falling clock
      d1 <= lf[0];
      d2 <= lf[1];
      dep <= lf[2];
      q1 <= (qm == 1) | (qm == 2 & lf[3]);
      q2 <= (qm == 1) | (qm == 2 & lf[4]);
      if (lf[7:4] == 4'h0)
        rq <= ~rq;
      clr_req <= (i >= clr_at && i < clr_at + 30);
      if (qm == 1 && i > 100) `CHECK(READY, 1'b0)
    end
    $display("test %s done, errors %0d", name, err_count);
  endtask : run

  // hold reset, move the strap while held, then release
  task automatic restart(input logic s);
    @(negedge CLK);
    RST_N <= 1'b0;
    sel <= s;
    repeat (16) @(negedge CLK);
    RST_N <= 1'b1;
  endtask : restart

  task automatic end_of_test();
    $display("checks %0d, errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  // main sequence
  initial
  begin
    repeat (16) @(posedge CLK);
    @(negedge CLK);
    RST_N <= 1'b1;
    run("oscillator source", 1'b0, 0, 9999);
    restart(1'b1);
    run("external source with clear", 1'b1, 0, 200);
    restart(1'b0);
    run("qualifiers off", 1'b0, 1, 9999);
    restart(1'b1);
    run("random mix with clear", 1'b1, 2, 300);
    end_of_test();
  end

  // watchdog
  initial
  begin
    repeat (5000) @(posedge CLK);
    err_count++;
    end_of_test();
  end
endmodule : clock_divider_ready_reset_sync_test
